// ===== design/axis_status_consts.vh
// Constants for the per-axis status flag words and their register bus.
`ifndef AXIS_STATUS_CONSTS_VH
`define AXIS_STATUS_CONSTS_VH

// Register indices; the byte address is four times the index.
`define ASF_IDX_CTRL_STATUS 8'h05
`define ASF_IDX_IO_STATUS 8'h06
`define ASF_IDX_MODE 8'h10
`define ASF_IDX_FLAG_CLEAR 8'h11
`define ASF_ADDR_CTRL_STATUS 8'h14
`define ASF_ADDR_IO_STATUS 8'h18
`define ASF_ADDR_MODE 8'h40
`define ASF_ADDR_FLAG_CLEAR 8'h44
`define ASF_ADDR_W 8

// Field positions in the control status word.
`define ASF_CTRL_CMD_OVF 4
`define ASF_CTRL_CMD_UNF 5
`define ASF_CTRL_FB_OVF 6
`define ASF_CTRL_FB_UNF 7
`define ASF_CTRL_SENSOR_ERR 8
`define ASF_CTRL_SERVO_ERR 9
`define ASF_CTRL_EXEC_ERR 10
`define ASF_CTRL_AXIS_WARN 11
`define ASF_CTRL_AXIS_ERR 12
`define ASF_CTRL_ZONE0 13
`define ASF_CTRL_STICKY_LO 4
`define ASF_CTRL_STICKY_HI 12
`define ASF_STICKY_W 9
`define ASF_ZONE_W 3

// Field positions in the external I/O status word.
`define ASF_IO_SERVO_ON 0
`define ASF_IO_ORIGIN_PROX 10
`define ASF_IO_USED_W 11

// Mode register: bit 0 selects linear position mode.
`define ASF_MODE_LINEAR 0
`define ASF_MODE_RESET 1'h1
`define ASF_WORD_W 16

`endif

// ===== design/sticky_flag_bank.v
// Bank of sticky event flags in which a set beats a clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank #(
   parameter W = 9
) (
   // Clock, reset and enable
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   // Per-bit set and clear
   input wire [W-1:0] i_set,
   input wire [W-1:0] i_clr,
   // Flags
   output wire [W-1:0] o_flags
);
   reg [W-1:0] flag_reg;
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : bit_cell
         always @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
               flag_reg[g] <= 1'b0;
            else if (i_ce)
               flag_reg[g] <= i_set[g] | (flag_reg[g] & ~i_clr[g]);
         end
      end
   endgenerate
   assign o_flags = flag_reg;
endmodule
`default_nettype wire

// ===== design/level_mirror.v
// Registered copy of live level inputs.
`timescale 1ns/1ps
`default_nettype none
module level_mirror #(
   parameter W = 14
) (
   // Clock, reset and enable
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   // Levels in and out
   input wire [W-1:0] i_d,
   output wire [W-1:0] o_q
);
   reg [W-1:0] q_reg;
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         q_reg <= {W{1'b0}};
      else if (i_ce)
         q_reg <= i_d;
   end
   assign o_q = q_reg;
endmodule
`default_nettype wire

// ===== design/axis_status_flag_words.v
// Per-axis control and external I/O status words behind an APB slave.
//
// How it works
// R1: Command position underflow in linear mode sets control bit 5.
// R2: Feedback position overflow in linear mode sets control bit 6.
// R3: Feedback position underflow in linear mode sets control bit 7.
// R4: Any external sensor fault sets control bit 8.
// R5: A servo drive alarm sets control bit 9.
// R6: A rejected axis operation command sets control bit 10.
// R7: A warning during memory operation sets control bit 11.
// R8: Any axis error sets control bit 12.
// R9: Control bits 13 to 15 follow membership of zones 0 to 2.
// R10: I/O bit 0 follows servomotor energised.
// R11: I/O bit 1 follows the alarm reset output.
// R12: I/O bit 2 follows the deviation counter reset output.
// R13: I/O bit 3 follows the forward torque limit output.
// R14: I/O bit 4 follows the reverse torque limit output.
// R15: I/O bit 5 follows main circuit voltage present.
// R16: I/O bit 6 follows the drive warning input.
// R17: I/O bit 7 follows drive ready.
// R18: I/O bit 8 follows the forward travel limit input.
// R19: I/O bit 9 follows the reverse travel limit input.
// R20: I/O bit 10 follows the origin proximity input.
// R21: Command position overflow in linear mode sets control bit 4.
// R22: Both status words are read-only; writes change no flag.
`timescale 1ns/1ps
`default_nettype none
`include "axis_status_consts.vh"
module axis_status_flag_words (
   // Clock, reset and enable
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`ASF_ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   // Position range events, one-cycle pulses
   input wire i_cmd_pos_ovf,
   input wire i_cmd_pos_unf,
   input wire i_fb_pos_ovf,
   input wire i_fb_pos_unf,
   // Error and warning events, one-cycle pulses
   input wire i_sensor_fault,
   input wire i_drive_alarm,
   input wire i_exec_reject,
   input wire i_mem_op_warning,
   input wire i_axis_fault,
   // Zone membership levels, bit n for zone n
   input wire [`ASF_ZONE_W-1:0] i_zone,
   // Servo drive outputs as driven by the unit
   input wire i_servo_on,
   input wire i_alarm_reset_out,
   input wire i_dev_cnt_reset_out,
   input wire i_fwd_torque_lim_out,
   input wire i_rev_torque_lim_out,
   // Servo drive and sensor inputs
   input wire i_main_circuit_on,
   input wire i_drive_warning,
   input wire i_servo_ready,
   input wire i_fwd_limit,
   input wire i_rev_limit,
   input wire i_origin_prox,
   // Status words for the local logic
   output wire [`ASF_WORD_W-1:0] o_ctrl_status,
   output wire [`ASF_WORD_W-1:0] o_io_status
);
   localparam MIRROR_W = `ASF_ZONE_W + `ASF_IO_USED_W;

   // Bus decode.
   wire setup_phase;
   wire access_done;
   wire hit_ctrl;
   wire hit_io;
   wire hit_mode;
   wire hit_clear;
   wire hit_any;
   wire wr_mode;
   wire wr_clear;

   // Register state.
   reg mode_linear_reg;
   reg mode_linear_next;
   reg [31:0] rdata_reg;
   reg [31:0] rdata_next;

   // Flag datapath.
   wire linear_mode;
   wire [`ASF_STICKY_W-1:0] sticky_set;
   wire [`ASF_STICKY_W-1:0] sticky_clr;
   wire [`ASF_STICKY_W-1:0] sticky_q;
   wire [MIRROR_W-1:0] mirror_d;
   wire [MIRROR_W-1:0] mirror_q;
   wire [`ASF_ZONE_W-1:0] zone_q;
   wire [`ASF_IO_USED_W-1:0] io_q;
   wire early_error;

   // The slave answers in the first access cycle; a frozen enable stalls it.
   assign o_pready = i_ce;
   assign setup_phase = i_psel & ~i_penable;
   assign access_done = i_psel & i_penable & i_ce;

   assign hit_ctrl = (i_paddr == `ASF_ADDR_CTRL_STATUS);
   assign hit_io = (i_paddr == `ASF_ADDR_IO_STATUS);
   assign hit_mode = (i_paddr == `ASF_ADDR_MODE);
   assign hit_clear = (i_paddr == `ASF_ADDR_FLAG_CLEAR);
   assign hit_any = hit_ctrl | hit_io | hit_mode | hit_clear;

   // Unmapped addresses answer with an error and have no effect.
   assign o_pslverr = i_psel & i_penable & ~hit_any;

   // R22: status writes ignored
   assign wr_mode = access_done & i_pwrite & hit_mode;
   assign wr_clear = access_done & i_pwrite & hit_clear;

   always @*
   begin
      mode_linear_next = mode_linear_reg;
      if (wr_mode)
         mode_linear_next = i_pwdata[`ASF_MODE_LINEAR];
   end

   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         mode_linear_reg <= `ASF_MODE_RESET;
      else if (i_ce)
         mode_linear_reg <= mode_linear_next;
   end

   assign linear_mode = mode_linear_reg;

   // Read data is taken in the setup cycle so it comes out of a flip-flop
   // in the access cycle; the trade is one cycle of age on live levels.
   always @*
   begin
      rdata_next = rdata_reg;
      if (setup_phase & ~i_pwrite)
      begin
         rdata_next = 32'h00000000;
         if (hit_ctrl)
            rdata_next[`ASF_WORD_W-1:0] = o_ctrl_status;
         else if (hit_io)
            rdata_next[`ASF_WORD_W-1:0] = o_io_status;
         else if (hit_mode)
            rdata_next[`ASF_MODE_LINEAR] = mode_linear_reg;
      end
   end

   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         rdata_reg <= 32'h00000000;
      else if (i_ce)
         rdata_reg <= rdata_next;
   end

   assign o_prdata = rdata_reg;

   // Outside linear mode the counters wrap by design, so range events
   // are dropped rather than latched.
   // R21: command overflow flag
   assign sticky_set[`ASF_CTRL_CMD_OVF-`ASF_CTRL_STICKY_LO] =
      i_cmd_pos_ovf & linear_mode;
   // R1: command underflow flag
   assign sticky_set[`ASF_CTRL_CMD_UNF-`ASF_CTRL_STICKY_LO] =
      i_cmd_pos_unf & linear_mode;
   // R2: feedback overflow flag
   assign sticky_set[`ASF_CTRL_FB_OVF-`ASF_CTRL_STICKY_LO] =
      i_fb_pos_ovf & linear_mode;
   // R3: feedback underflow flag
   assign sticky_set[`ASF_CTRL_FB_UNF-`ASF_CTRL_STICKY_LO] =
      i_fb_pos_unf & linear_mode;
   // R4: sensor error flag
   assign sticky_set[`ASF_CTRL_SENSOR_ERR-`ASF_CTRL_STICKY_LO] =
      i_sensor_fault;
   // R5: servo error flag
   assign sticky_set[`ASF_CTRL_SERVO_ERR-`ASF_CTRL_STICKY_LO] =
      i_drive_alarm;
   // R6: execution error flag
   assign sticky_set[`ASF_CTRL_EXEC_ERR-`ASF_CTRL_STICKY_LO] =
      i_exec_reject;
   // R7: axis warning flag
   assign sticky_set[`ASF_CTRL_AXIS_WARN-`ASF_CTRL_STICKY_LO] =
      i_mem_op_warning;

   // R8: summary axis error
   assign early_error = |sticky_set[`ASF_CTRL_EXEC_ERR-`ASF_CTRL_STICKY_LO:0];
   assign sticky_set[`ASF_CTRL_AXIS_ERR-`ASF_CTRL_STICKY_LO] =
      i_axis_fault | early_error;

   // Write-one-to-clear; a set in the same cycle still wins.
   assign sticky_clr = wr_clear ?
      i_pwdata[`ASF_CTRL_STICKY_HI:`ASF_CTRL_STICKY_LO] :
      {`ASF_STICKY_W{1'b0}};

   sticky_flag_bank #(
      .W(`ASF_STICKY_W)
   ) u_sticky (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_set(sticky_set),
      .i_clr(sticky_clr),
      .o_flags(sticky_q)
   );

   // R10: servo on level
   // R11: alarm reset level
   // R12: deviation reset level
   // R13: forward torque level
   // R14: reverse torque level
   // R15: main circuit level
   // R16: drive warning level
   // R17: servo ready level
   // R18: forward limit level
   // R19: reverse limit level
   // R20: origin proximity level
   // R9: zone levels
   assign mirror_d = {
      i_zone,
      i_origin_prox,
      i_rev_limit,
      i_fwd_limit,
      i_servo_ready,
      i_drive_warning,
      i_main_circuit_on,
      i_rev_torque_lim_out,
      i_fwd_torque_lim_out,
      i_dev_cnt_reset_out,
      i_alarm_reset_out,
      i_servo_on
   };

   level_mirror #(
      .W(MIRROR_W)
   ) u_mirror (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_d(mirror_d),
      .o_q(mirror_q)
   );

   assign zone_q = mirror_q[MIRROR_W-1:`ASF_IO_USED_W];
   assign io_q = mirror_q[`ASF_IO_USED_W-1:0];

   // Bits 0 to 3 of the control word and 11 to 15 of the I/O word are
   // owned by other blocks and read as zero here.
   assign o_ctrl_status = {zone_q, sticky_q, 4'h0};
   assign o_io_status = {5'h00, io_q};
endmodule
`default_nettype wire

// ===== dv/axis_status_flag_words_sva.sv
// Port assertions for the axis status flag words.
`timescale 1ns/1ps
`default_nettype none
`include "axis_status_consts.vh"
module axis_status_flag_words_sva (
   // Clock and bus
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`ASF_ADDR_W-1:0] i_paddr,
   input wire o_pslverr,
   // Sources and words
   input wire i_drive_alarm,
   input wire [`ASF_ZONE_W-1:0] i_zone,
   input wire i_servo_on,
   input wire i_origin_prox,
   input wire [`ASF_WORD_W-1:0] o_ctrl_status,
   input wire [`ASF_WORD_W-1:0] o_io_status
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire mapped = i_paddr == `ASF_ADDR_CTRL_STATUS
      || i_paddr == `ASF_ADDR_IO_STATUS || i_paddr == `ASF_ADDR_MODE
      || i_paddr == `ASF_ADDR_FLAG_CLEAR;
   wire clr_wr = i_psel && i_pwrite && i_paddr == `ASF_ADDR_FLAG_CLEAR;
   a_slverr_map: assert property (o_pslverr == (i_psel && i_penable && !mapped))
      else $error("slave error wrong");
   a_zone_mirror: assert property (i_ce |=> o_ctrl_status[15:13] == $past(i_zone))
      else $error("zone bits wrong");
   a_servo_mirror: assert property (i_ce |=> o_io_status[0] == $past(i_servo_on))
      else $error("servo on bit wrong");
   a_prox_mirror: assert property (i_ce |=> o_io_status[10] == $past(i_origin_prox))
      else $error("proximity bit wrong");
   a_alarm_sets: assert property (i_ce && i_drive_alarm |=> o_ctrl_status[9] && o_ctrl_status[12])
      else $error("alarm flag missed");
   a_alarm_cause: assert property ($rose(o_ctrl_status[9]) |-> $past(i_drive_alarm))
      else $error("alarm flag without cause");
   a_error_summary: assert property ($rose(o_ctrl_status[9]) |-> o_ctrl_status[12])
      else $error("axis error flag missed");
   a_flags_hold: assert property (!clr_wr |=> ($past(o_ctrl_status[12:4]) & ~o_ctrl_status[12:4]) == 9'h0)
      else $error("flag dropped without clear");
   cover property (i_drive_alarm ##1 o_ctrl_status[9]);
   cover property (o_pslverr);
   cover property (o_ctrl_status[15:13] == 3'h7);
endmodule
bind axis_status_flag_words axis_status_flag_words_sva u_sva (.i_clk(i_clk),
   .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pslverr(o_pslverr),
   .i_drive_alarm(i_drive_alarm), .i_zone(i_zone), .i_servo_on(i_servo_on),
   .i_origin_prox(i_origin_prox), .o_ctrl_status(o_ctrl_status),
   .o_io_status(o_io_status));
`default_nettype wire

// ===== dv/servo_drive_model.sv
// Servo drive and sensor model: registered levels and an alarm pulse.
`timescale 1ns/1ps
`default_nettype none
module servo_drive_model (
   // Clock and requests
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [5:0] i_level_req,
   input wire logic i_alarm_req,
   // Lines towards the unit
   output var logic [5:0] o_levels,
   output var logic o_alarm
);
   // A real drive answers a cycle late, so the model does too.
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_levels <= 6'h0;
         o_alarm <= 1'b0;
      end
      else
      begin
         o_levels <= i_level_req;
         o_alarm <= i_alarm_req;
      end
   end
endmodule
`default_nettype wire

// ===== dv/axis_status_flag_words_tb.sv
// Testbench for the axis status flag words.
`timescale 1ns/1ps
`default_nettype none
`include "axis_status_consts.vh"
module axis_status_flag_words_tb;
   logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, e;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, r, x;
   logic [10:0] io_v = 0;
   logic [8:0] ev = 0;
   logic [2:0] zone = 0;
   wire [31:0] prdata;
   wire [15:0] cs, ios;
   wire pready, pslverr, alarm;
   wire [5:0] lv;
   int err_count = 0, check_count = 0, i, j;
   always #50 clk = ~clk;
   servo_drive_model u_drv (.i_clk(clk), .i_rst(rst), .i_level_req(io_v[10:5]),
      .i_alarm_req(ev[5]), .o_levels(lv), .o_alarm(alarm));
   axis_status_flag_words u_dut (.i_clk(clk), .i_rst(rst), .i_ce(ce),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_cmd_pos_ovf(ev[0]), .i_cmd_pos_unf(ev[1]),
      .i_fb_pos_ovf(ev[2]), .i_fb_pos_unf(ev[3]), .i_sensor_fault(ev[4]),
      .i_drive_alarm(alarm), .i_exec_reject(ev[6]), .i_mem_op_warning(ev[7]),
      .i_axis_fault(ev[8]), .i_zone(zone), .i_servo_on(io_v[0]),
      .i_alarm_reset_out(io_v[1]), .i_dev_cnt_reset_out(io_v[2]),
      .i_fwd_torque_lim_out(io_v[3]), .i_rev_torque_lim_out(io_v[4]),
      .i_main_circuit_on(lv[0]), .i_drive_warning(lv[1]),
      .i_servo_ready(lv[2]), .i_fwd_limit(lv[3]), .i_rev_limit(lv[4]),
      .i_origin_prox(lv[5]), .o_ctrl_status(cs), .o_io_status(ios));
   task complete_run;
   begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] xp);
   begin
      check_count++;
      if (s !== xp)
      begin
         $display("Error %s expected %h seen %h", nm, xp, s);
         err_count++;
      end
   end
   endtask
   // One APB transfer; the wait for pready is bounded.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
   begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20)
      begin
         err_count++;
         complete_run;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task pulse(input int k);
   begin
      @(posedge clk);
      ev <= 9'h1 << k;
      @(posedge clk);
      ev <= 9'h0;
      repeat (3) @(posedge clk);
   end
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("ctrl reset", r, 0);
      apb(0, `ASF_ADDR_MODE, 0); chk("mode reset", r, 1);
      for (i = 0; i < 11; i++)
      begin
         io_v <= 11'h1 << i;
         repeat (3) @(posedge clk);
         apb(0, `ASF_ADDR_IO_STATUS, 0); chk("io", r, 32'h1 << i);
         chk("io word", ios, 32'h1 << i);
      end
      io_v <= 11'h0;
      for (i = 0; i < 8; i++)
      begin
         zone <= i[2:0];
         repeat (2) @(posedge clk);
         apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("zone", r, i << 13);
         chk("zone word", cs, i << 13);
      end
      zone <= 3'h0;
      $display("levels done");
      for (j = 0; j < 9; j++)
      begin
         pulse(j);
         x = (32'h10 << j) | ((j != 7) ? 32'h1000 : 32'h0);
         apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("event", r, x);
         apb(1, `ASF_ADDR_FLAG_CLEAR, 32'h1ff0);
         apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("cleared", r, 0);
      end
      $display("events done");
      pulse(8);
      apb(1, `ASF_ADDR_CTRL_STATUS, 32'hffff);
      apb(1, `ASF_ADDR_IO_STATUS, 32'hffff);
      apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("ctrl ro", r, 32'h1000);
      apb(0, `ASF_ADDR_IO_STATUS, 0); chk("io ro", r, 0);
      apb(1, `ASF_ADDR_FLAG_CLEAR, 32'h1ff0);
      apb(0, 8'h20, 0); chk("unmapped", e, 1);
      apb(1, `ASF_ADDR_MODE, 0);
      for (j = 0; j < 4; j++)
         pulse(j);
      apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("mode off", r, 0);
      apb(1, `ASF_ADDR_MODE, 1);
      // A clear that meets a new sensor event in one edge must lose.
      fork
         apb(1, `ASF_ADDR_FLAG_CLEAR, 32'h100);
         begin
            @(posedge clk);
            pulse(4);
         end
      join
      apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("set wins", r, 32'h1100);
      apb(1, `ASF_ADDR_FLAG_CLEAR, 32'h1ff0);
      // With the enable low an event is not taken and pready drops.
      @(posedge clk);
      ce <= 1'b0;
      ev <= 9'h10;
      @(posedge clk);
      ev <= 9'h0;
      chk("pready frozen", pready, 0);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      apb(0, `ASF_ADDR_CTRL_STATUS, 0); chk("frozen", r, 0);
      chk("ctrl word", cs, 0);
      $display("access done");
      complete_run;
   end
endmodule
`default_nettype wire
